// ---- pcw_top.sv ----
// Purpose: port codeword capture and waveform sequencer with AXI4-Lite registers
// Assumes: single master, one read and one write under way at a time
// Notes: interrupt status clears on read; a new event in that cycle survives
`timescale 1ns/1ps
module pcw_top (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [pcw_pkg::AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [pcw_pkg::AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [pcw_pkg::PORT_W-1:0] port_data_i,
  input wire logic port_strobe_i,
  input wire logic trig_i,
  input wire logic sync_all_ready_i,
  output logic sync_ready_o,
  output logic wave_play_o,
  output logic [pcw_pkg::CW_W-1:0] wave_sel_o,
  output logic irq_o
);
  import pcw_pkg::*;
  // ==========================================
  // state
  typedef struct packed {
    logic aw_full;
    logic [AW-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    pcw_port_cfg_s cfg;
    logic rerun;
    logic sync_en;
    logic [LEN_W-1:0] prog_len;
    pcw_ctab_e ctab;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [PC_W-1:0] imem_addr;
    logic imem_we;
    logic [PC_W-1:0] imem_waddr;
    logic [31:0] imem_wdata;
    pcw_seq_e seq;
    logic [PC_W-1:0] pc;
    logic armed;
    logic cw_pend;
    logic [CW_W-1:0] cw;
    logic play;
    logic [CW_W-1:0] wave_sel;
  } pcw_top_s;
  pcw_top_s s;
  pcw_top_s next_s;
  logic [PORT_W-1:0] high_bits;
  logic [PORT_W-1:0] low_bits;
  logic [CW_W-1:0] codeword;
  logic cw_valid;
  logic timing_err;
  logic [31:0] imem_rdata;
  logic [21:0] usage_prod;
  logic [6:0] usage_pct;
  // percent of capacity, rounded down; a shift divides since capacity is a power of two
  assign usage_prod = 22'(s.prog_len) * PCT_FULL; // RQ12
  assign usage_pct = usage_prod[PCT_SHIFT +: 7];
  // ==========================================
  // register decode
  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic m;
    m = 1'b0;
    case (a)
      ADDR_CTRL, ADDR_PORT_CFG, ADDR_MASK, ADDR_HIGH, ADDR_LOW: m = 1'b1;
      ADDR_STATUS, ADDR_COUNTER, ADDR_PROG_LEN, ADDR_USAGE: m = 1'b1;
      ADDR_IMEM_ADDR, ADDR_IMEM_DATA, ADDR_CTAB, ADDR_IRQ_ST: m = 1'b1;
      ADDR_IRQ_MASK, ADDR_CODEWORD: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction : is_mapped
  function automatic logic [31:0] rd_val(input logic [AW-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      ADDR_CTRL: begin
        v[CTRL_RERUN] = s.rerun;
        v[CTRL_SYNC] = s.sync_en;
      end
      ADDR_PORT_CFG: begin
        v[CFG_QSEL_LSB +: 4] = s.cfg.qual_sel;
        v[CFG_POL_LSB +: 2] = s.cfg.pol;
        v[CFG_SHIFT_LSB +: 5] = s.cfg.shift;
      end
      ADDR_MASK: v[CW_W-1:0] = s.cfg.mask;
      ADDR_HIGH: v = high_bits; // RQ6
      ADDR_LOW: v = low_bits; // RQ7
      ADDR_STATUS: begin
        v[STAT_STATE_LSB +: 2] = s.seq; // RQ10
        v[STAT_CTAB_LSB +: 2] = s.ctab; // RQ14
        v[STAT_SYNC] = sync_ready_o;
      end
      ADDR_COUNTER: v[PC_W-1:0] = s.pc; // RQ11
      ADDR_PROG_LEN: v[LEN_W-1:0] = s.prog_len;
      ADDR_USAGE: v[6:0] = usage_pct; // RQ12
      ADDR_IMEM_ADDR: v[PC_W-1:0] = s.imem_addr;
      ADDR_IRQ_ST: v[IRQ_W-1:0] = s.irq_st;
      ADDR_IRQ_MASK: v[IRQ_W-1:0] = s.irq_mask;
      ADDR_CODEWORD: v[CW_W-1:0] = codeword;
      default: v = '0;
    endcase
    return v;
  endfunction : rd_val
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : strb_merge
  // ==========================================
  // next state
  always_comb begin
    logic [AW-1:0] wa;
    logic [AW-1:0] ra;
    logic [31:0] wd;
    logic [15:0] cnt;
    logic [LEN_W-1:0] last;
    logic start_req;
    logic stop_req;
    logic adv;
    logic fin;
    wa = '0;
    ra = '0;
    wd = '0;
    cnt = '0;
    last = s.prog_len - 15'h0001;
    start_req = 1'b0;
    stop_req = 1'b0;
    adv = 1'b0;
    fin = 1'b0;
    next_s = s;
    next_s.imem_we = 1'b0;
    next_s.play = 1'b0;
    // write address and data are taken in either order
    if (s_axi_awvalid_i && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata_i;
      next_s.w_strb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_full && s.w_full && !s.bvalid) begin
      wa = {s.aw_addr[AW-1:2], 2'b00};
      wd = strb_merge(rd_val(wa), s.w_data, s.w_strb);
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        ADDR_CTRL: begin
          start_req = wd[CTRL_START];
          stop_req = wd[CTRL_STOP];
          next_s.rerun = wd[CTRL_RERUN];
          next_s.sync_en = wd[CTRL_SYNC];
        end
        ADDR_PORT_CFG: begin
          next_s.cfg.qual_sel = wd[CFG_QSEL_LSB +: 4]; // RQ1
          next_s.cfg.pol = pcw_pol_e'(wd[CFG_POL_LSB +: 2]); // RQ2
          next_s.cfg.shift = wd[CFG_SHIFT_LSB +: 5]; // RQ3
        end
        ADDR_MASK: next_s.cfg.mask = wd[CW_W-1:0]; // RQ4
        ADDR_PROG_LEN: begin
          // oversize lengths clamp to the store's capacity
          if ((|wd[31:LEN_W]) || (wd[LEN_W-1:0] > IMEM_CAP)) begin
            next_s.prog_len = IMEM_CAP; // RQ12
          end else begin
            next_s.prog_len = wd[LEN_W-1:0];
          end
        end
        ADDR_IMEM_ADDR: next_s.imem_addr = wd[PC_W-1:0];
        ADDR_IMEM_DATA: begin
          next_s.imem_we = 1'b1;
          next_s.imem_waddr = s.imem_addr;
          next_s.imem_wdata = wd;
          next_s.imem_addr = s.imem_addr + 14'h0001;
        end
        ADDR_CTAB: begin
          cnt = wd[CTAB_CNT_LSB +: 16];
          if (wd[CTAB_CLR]) begin
            next_s.ctab = CTAB_NONE; // RQ14
          end else if (wd[CTAB_LOAD]) begin
            next_s.ctab = (cnt == 16'h0000 || cnt > CTAB_MAX) ? CTAB_ERR : CTAB_OK; // RQ14
          end
        end
        ADDR_IRQ_MASK: next_s.irq_mask = wd[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // read side: one outstanding read, answered the cycle after acceptance
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !s.rvalid) begin
      ra = {s_axi_araddr_i[AW-1:2], 2'b00};
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val(ra);
      next_s.rresp = is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      if (ra == ADDR_IRQ_ST) begin
        next_s.irq_st = '0;
      end
    end
    // sequencer
    unique case (s.seq)
      SEQ_NOT_READY: begin
        if (s.prog_len != '0) begin
          next_s.seq = SEQ_READY; // RQ10
        end
      end
      SEQ_READY: begin
        if (start_req) begin
          next_s.armed = 1'b1;
        end
        if (s.armed && (!s.sync_en || sync_all_ready_i)) begin
          next_s.seq = SEQ_RUN; // RQ9
          next_s.pc = '0;
          next_s.armed = 1'b0;
        end
      end
      SEQ_RUN: begin
        unique case (imem_rdata[OP_LSB +: 2])
          OP_NOP: adv = 1'b1;
          OP_WAIT: begin
            if (trig_i) begin
              adv = 1'b1;
            end else begin
              next_s.seq = SEQ_WAIT; // RQ10
            end
          end
          OP_PLAY: begin
            // stalls here until a qualified codeword has arrived
            if (s.cw_pend) begin
              adv = 1'b1;
              next_s.play = 1'b1; // RQ5
              next_s.wave_sel = s.cw; // RQ5
              next_s.cw_pend = 1'b0;
            end
          end
          OP_END: fin = 1'b1;
        endcase
      end
      SEQ_WAIT: begin
        if (trig_i) begin
          next_s.seq = SEQ_RUN;
          adv = 1'b1;
        end
      end
    endcase
    if (adv && ({1'b0, s.pc} == last)) begin
      fin = 1'b1;
    end
    if (fin) begin
      if (s.rerun) begin
        next_s.seq = SEQ_RUN; // RQ13
        next_s.pc = '0; // RQ13
      end else begin
        next_s.seq = SEQ_READY;
      end
    end else if (adv) begin
      next_s.pc = s.pc + 14'h0001; // RQ11
    end
    if (stop_req) begin
      next_s.seq = SEQ_READY;
      next_s.armed = 1'b0;
    end
    if (next_s.prog_len == '0) begin
      next_s.seq = SEQ_NOT_READY; // RQ10
      next_s.armed = 1'b0;
    end
    // a capture landing with a consume keeps the newer word pending
    if (cw_valid) begin
      next_s.cw_pend = 1'b1;
      next_s.cw = codeword;
    end
    // events set after the read clear so the set wins
    if (timing_err) begin
      next_s.irq_st[IRQ_TERR] = 1'b1; // RQ8
    end
    if (cw_valid) begin
      next_s.irq_st[IRQ_CW] = 1'b1;
    end
    if (fin) begin
      next_s.irq_st[IRQ_DONE] = 1'b1;
    end
  end
  // ==========================================
  // registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.cfg.mask <= MASK_RST;
      s.irq_mask <= IRQ_MASK_RST;
    end else begin
      s <= next_s;
    end
  end
  // ==========================================
  // submodules
  pcw_extract u_extract (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .port_i(port_data_i),
    .strobe_i(port_strobe_i),
    .cfg_i(s.cfg),
    .high_bits_o(high_bits),
    .low_bits_o(low_bits),
    .codeword_o(codeword),
    .cw_valid_o(cw_valid),
    .timing_err_o(timing_err)
  );
  // read address follows next pc so the word for pc is ready on arrival
  pcw_imem u_imem (
    .mclk_i(mclk_i),
    .we_i(s.imem_we),
    .waddr_i(s.imem_waddr),
    .wdata_i(s.imem_wdata),
    .raddr_i(next_s.pc),
    .rdata_o(imem_rdata)
  );
  // ==========================================
  // outputs
  assign s_axi_awready_o = !s.aw_full;
  assign s_axi_wready_o = !s.w_full;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = !s.rvalid;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign sync_ready_o = s.armed && s.sync_en && (s.seq == SEQ_READY); // RQ9
  assign wave_play_o = s.play;
  assign wave_sel_o = s.wave_sel;
  assign irq_o = |(s.irq_st & s.irq_mask);
endmodule : pcw_top

// ---- pcw_pkg.sv ----
// Purpose: shared constants, enums and carriers of the port codeword block
// Assumes: one clock mclk_i at 50 MHz, synchronous active-high reset
// Notes: offsets are byte addresses of aligned 32-bit words on AXI4-Lite
// How it works
// RQ1 - one of port bits 16..31 is qualifier
// RQ2 - qualifier polarity: ignore, low, high, either
// RQ3 - shift sampled port by 0 to 31
// RQ4 - codeword is shifted port AND 10-bit mask
// RQ5 - codeword picks wave for port playback instruction
// RQ6 - status word shows port lines seen high
// RQ7 - status word shows port lines seen low
// RQ8 - flag port change coinciding with strobe change
// RQ9 - synced channel starts only when all ready
// RQ10 - report ready, running, waiting, or not ready
// RQ11 - counter shows current instruction position
// RQ12 - at most 16384 instructions, usage in percent
// RQ13 - rerun restarts program after each completion
// RQ14 - command table: none, loaded, or error
// RQ15 - shift moves field down to bit zero
// RQ16 - capture on strobe when qualifier condition holds
package pcw_pkg;
  // ==========================================
  // widths and capacities
  localparam int unsigned PORT_W = 32;
  localparam int unsigned CW_W = 10;
  localparam int unsigned IMEM_DEPTH = 16384;
  localparam int unsigned PC_W = 14;
  localparam int unsigned LEN_W = 15;
  localparam int unsigned AW = 8;
  localparam int unsigned IRQ_W = 3;
  localparam logic [4:0] QUAL_BASE = 5'h10;
  localparam logic [LEN_W-1:0] IMEM_CAP = 15'h4000;
  localparam logic [21:0] PCT_FULL = 22'h000064;
  localparam int unsigned PCT_SHIFT = 14;
  localparam logic [15:0] CTAB_MAX = 16'h0400;
  // ==========================================
  // register offsets
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_PORT_CFG = 8'h04;
  localparam logic [AW-1:0] ADDR_MASK = 8'h08;
  localparam logic [AW-1:0] ADDR_HIGH = 8'h0C;
  localparam logic [AW-1:0] ADDR_LOW = 8'h10;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h14;
  localparam logic [AW-1:0] ADDR_COUNTER = 8'h18;
  localparam logic [AW-1:0] ADDR_PROG_LEN = 8'h1C;
  localparam logic [AW-1:0] ADDR_USAGE = 8'h20;
  localparam logic [AW-1:0] ADDR_IMEM_ADDR = 8'h24;
  localparam logic [AW-1:0] ADDR_IMEM_DATA = 8'h28;
  localparam logic [AW-1:0] ADDR_CTAB = 8'h2C;
  localparam logic [AW-1:0] ADDR_IRQ_ST = 8'h30;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h34;
  localparam logic [AW-1:0] ADDR_CODEWORD = 8'h38;
  // ==========================================
  // field positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STOP = 1;
  localparam int unsigned CTRL_RERUN = 2;
  localparam int unsigned CTRL_SYNC = 3;
  localparam int unsigned CFG_QSEL_LSB = 0;
  localparam int unsigned CFG_POL_LSB = 4;
  localparam int unsigned CFG_SHIFT_LSB = 8;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_CTAB_LSB = 4;
  localparam int unsigned STAT_SYNC = 8;
  localparam int unsigned CTAB_CLR = 0;
  localparam int unsigned CTAB_LOAD = 1;
  localparam int unsigned CTAB_CNT_LSB = 16;
  localparam int unsigned IRQ_TERR = 0;
  localparam int unsigned IRQ_CW = 1;
  localparam int unsigned IRQ_DONE = 2;
  localparam int unsigned OP_LSB = 30;
  // ==========================================
  // opcodes, responses, reset values
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_WAIT = 2'h1;
  localparam logic [1:0] OP_PLAY = 2'h2;
  localparam logic [1:0] OP_END = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CW_W-1:0] MASK_RST = 10'h000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // ==========================================
  // types
  typedef enum logic [1:0] {POL_NONE, POL_LOW, POL_HIGH, POL_BOTH} pcw_pol_e;
  typedef enum logic [1:0] {SEQ_NOT_READY, SEQ_READY, SEQ_RUN, SEQ_WAIT} pcw_seq_e;
  typedef enum logic [1:0] {CTAB_NONE, CTAB_OK, CTAB_ERR} pcw_ctab_e;
  typedef struct packed {
    logic [3:0] qual_sel;
    pcw_pol_e pol;
    logic [4:0] shift;
    logic [CW_W-1:0] mask;
  } pcw_port_cfg_s;
endpackage : pcw_pkg

// ---- pcw_extract.sv ----
// Purpose: samples the port, qualifies strobes, forms codewords
// Assumes: port and strobe synchronous to mclk_i
// Notes: strobe event is a rising edge of the strobe input
`timescale 1ns/1ps
module pcw_extract (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [pcw_pkg::PORT_W-1:0] port_i,
  input wire logic strobe_i,
  input wire pcw_pkg::pcw_port_cfg_s cfg_i,
  output logic [pcw_pkg::PORT_W-1:0] high_bits_o,
  output logic [pcw_pkg::PORT_W-1:0] low_bits_o,
  output logic [pcw_pkg::CW_W-1:0] codeword_o,
  output logic cw_valid_o,
  output logic timing_err_o
);
  import pcw_pkg::*;
  typedef struct packed {
    logic primed;
    logic strobe;
    logic [PORT_W-1:0] port;
    logic [PORT_W-1:0] low;
    logic [CW_W-1:0] cw;
    logic cw_valid;
    logic terr;
  } pcw_ext_s;
  pcw_ext_s s;
  pcw_ext_s next_s;
  logic [PORT_W-1:0] shifted;
  logic qual;
  logic qual_ok;
  always_comb begin
    shifted = port_i >> cfg_i.shift; // RQ3 RQ15
    qual = port_i[QUAL_BASE + {1'b0, cfg_i.qual_sel}]; // RQ1
    unique case (cfg_i.pol)
      POL_NONE: qual_ok = 1'b1;
      POL_LOW: qual_ok = !qual; // RQ2
      POL_HIGH: qual_ok = qual; // RQ2
      POL_BOTH: qual_ok = 1'b1;
    endcase
    next_s = s;
    next_s.primed = 1'b1;
    next_s.strobe = strobe_i;
    next_s.port = port_i; // RQ6
    next_s.low = ~port_i; // RQ7
    next_s.cw_valid = s.primed && strobe_i && !s.strobe && qual_ok; // RQ16
    if (next_s.cw_valid) begin
      next_s.cw = shifted[CW_W-1:0] & cfg_i.mask; // RQ4
    end
    // first sample after reset has no history to compare against
    next_s.terr = s.primed && (strobe_i != s.strobe) && (port_i != s.port); // RQ8
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign high_bits_o = s.port;
  assign low_bits_o = s.low;
  assign codeword_o = s.cw;
  assign cw_valid_o = s.cw_valid;
  assign timing_err_o = s.terr;
endmodule : pcw_extract

// ---- pcw_imem.sv ----
// Purpose: instruction store of the sequencer
// Assumes: one write and one read port, read registered
// Notes: no reset on contents; read of a word written this cycle is stale
`timescale 1ns/1ps
module pcw_imem (
  input wire logic mclk_i,
  input wire logic we_i,
  input wire logic [pcw_pkg::PC_W-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [pcw_pkg::PC_W-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  import pcw_pkg::*;
  logic [31:0] mem [IMEM_DEPTH];
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : pcw_imem

// ---- pcw_props.sv ----
// Purpose: port-level checks of pcw_top bus and sequencer outputs
// Assumes: one clock mclk_i, synchronous reset sys_rst_i
// Notes: bound into every pcw_top instance
`timescale 1ns/1ps
module pcw_props (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic sync_all_ready_i,
  input wire logic sync_ready_o,
  input wire logic wave_play_o,
  input wire logic [pcw_pkg::CW_W-1:0] wave_sel_o
);
  import pcw_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================
  // bus handshakes
  property p_wr_resp;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response not on time");
  property p_b_done;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  property p_rd_resp;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data not on time");
  property p_r_done;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read slot not freed");
  property p_aw_block;
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write address taken twice");
  // ==========================================
  // playback and start sync
  property p_sel_hold;
    $changed(wave_sel_o) |-> wave_play_o;
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection moved without play");
  // a stop write may drop the wait, seen as a fresh response
  property p_sync_wait;
    sync_ready_o && !sync_all_ready_i |=> (sync_ready_o || $rose(s_axi_bvalid_o)) && !wave_play_o;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("started before all ready");
  property p_sync_go;
    sync_ready_o && sync_all_ready_i |=> !sync_ready_o;
  endproperty
  a_sync_go: assert property (p_sync_go) else $error("did not start when all ready");
  c_play: cover property (wave_play_o);
  c_sync: cover property (sync_ready_o && sync_all_ready_i);
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule : pcw_props

bind pcw_top pcw_props u_props (.mclk_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .sync_all_ready_i,
  .sync_ready_o, .wave_play_o, .wave_sel_o);

// ---- pcw_ctrl_model.sv ----
// Purpose: external controller driving words and strobe on the port
// Assumes: drives just after mclk_i rising edges
// Notes: bad mode flips data with the strobe rise
`timescale 1ns/1ps
module pcw_ctrl_model (
  input wire logic mclk_i,
  output logic [31:0] port_o,
  output logic strobe_o
);
  initial begin
    port_o = 32'h0;
    strobe_o = 1'b0;
  end
  // ==========================================
  // one strobed word, data settled a cycle ahead
  task send(input logic [31:0] d, input logic bad);
    @(posedge mclk_i);
    port_o <= d;
    @(posedge mclk_i);
    strobe_o <= 1'b1;
    if (bad) port_o <= ~d;
    @(posedge mclk_i);
    strobe_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : send
endmodule : pcw_ctrl_model

// ---- pcw_top_tb.sv ----
// Purpose: register-level tests of pcw_top
// Assumes: AXI4-Lite master tasks, port driven by pcw_ctrl_model
// Notes: expected values derived from the register map
`timescale 1ns/1ps
module pcw_top_tb;
  import pcw_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, v, d, rdata, port;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic trig = 1'b0, sall = 1'b0, awrdy, wrdy, bvalid, arrdy, rvalid, srdy, play, irq, strobe;
  logic q, cap;
  logic [1:0] bresp, rresp, p;
  logic [3:0] qs;
  logic [4:0] sh;
  logic [9:0] sel, ecw;
  logic [15:0] ct [4] = '{16'h0, 16'h1, 16'h400, 16'h401};
  logic [1:0] ce [4] = '{2'h2, 2'h1, 2'h1, 2'h2};
  int mismatches = 0, checks = 0;
  always #10 mclk_i = ~mclk_i;
  pcw_ctrl_model m (.mclk_i(mclk_i), .port_o(port), .strobe_o(strobe));
  pcw_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .port_data_i(port), .port_strobe_i(strobe), .trig_i(trig),
    .sync_all_ready_i(sall), .sync_ready_o(srdy), .wave_play_o(play), .wave_sel_o(sel),
    .irq_o(irq));
  // ==========================================
  // reporting
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task tmo;
    mismatches++;
    give_verdict();
  endtask : tmo
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  function automatic logic [1:0] er(input logic [7:0] a);
    return (a > ADDR_CODEWORD) ? RESP_SLVERR : RESP_OKAY;
  endfunction : er
  // ==========================================
  // bus master
  task wr(input logic [7:0] a, input logic [31:0] dt);
    int n;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (awvalid && awrdy) awvalid <= 1'b0;
      if (wvalid && wrdy) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) tmo();
    bready <= 1'b0;
    chk("bresp", {30'h0, er(a)}, {30'h0, bresp});
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (arvalid && arrdy) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) tmo();
    rready <= 1'b0;
    v = rdata;
    chk("rresp", {30'h0, er(a)}, {30'h0, rresp});
  endtask : rd
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    rd(a);
    chk(nm, ex, v);
  endtask : rdc
  task wplay;
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk_i);
      if (play) break;
    end
    if (n == 200) tmo();
  endtask : wplay
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rdc("mask", ADDR_MASK, 32'h0);
    rdc("imask", ADDR_IRQ_MASK, 32'h0);
    rdc("status", ADDR_STATUS, 32'h0);
    rdc("cw", ADDR_CODEWORD, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
    wr(8'h40, 32'h1);
    ecw = 10'h0;
    for (int i = 0; i < 8; i++) begin
      p = i[2:1];
      q = i[0];
      qs = {p, p};
      sh = {p, p, 1'b1};
      d = (32'hC35A96E1 ^ {8{i[3:0]}}) & ~(32'h1 << (5'h10 + qs));
      d = d | ({31'h0, q} << (5'h10 + qs));
      wr(ADDR_MASK, 32'h3FF >> p);
      wr(ADDR_PORT_CFG, {19'h0, sh, 2'h0, p, qs});
      m.send(d, 1'b0);
      cap = (p == 2'h0) || (p == 2'h3) || (p == {q, ~q});
      if (cap) ecw = 10'(d >> sh) & 10'(32'h3FF >> p);
      rdc("irq_st", ADDR_IRQ_ST, {29'h0, 1'b0, cap, 1'b0});
      rdc("cw", ADDR_CODEWORD, {22'h0, ecw});
    end
    rdc("high", ADDR_HIGH, d);
    rdc("low", ADDR_LOW, ~d);
    m.send(32'h1234, 1'b1);
    rd(ADDR_IRQ_ST);
    chk("terr", 32'h1, {31'h0, v[IRQ_TERR]});
    wr(ADDR_IRQ_MASK, 32'h2);
    m.send(32'h5, 1'b0);
    chk("irq_o", 32'h1, {31'h0, irq});
    rd(ADDR_IRQ_ST);
    @(posedge mclk_i);
    chk("irq_o", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0);
    m.send(32'h6, 1'b0);
    chk("irq_o", 32'h0, {31'h0, irq});
    rd(ADDR_IRQ_ST);
    wr(ADDR_MASK, 32'h3FF);
    wr(ADDR_PORT_CFG, 32'h30);
    wr(ADDR_IMEM_ADDR, 32'h0);
    wr(ADDR_IMEM_DATA, {OP_WAIT, 30'h0});
    wr(ADDR_IMEM_DATA, {OP_PLAY, 30'h0});
    wr(ADDR_IMEM_DATA, {OP_NOP, 30'h0});
    wr(ADDR_IMEM_DATA, {OP_END, 30'h0});
    wr(ADDR_PROG_LEN, 32'h4E20);
    rdc("len", ADDR_PROG_LEN, 32'h4000);
    rdc("usage", ADDR_USAGE, 32'h64);
    wr(ADDR_PROG_LEN, 32'h3);
    rdc("usage", ADDR_USAGE, 32'h0);
    rdc("status", ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    repeat (3) @(posedge mclk_i);
    rdc("status", ADDR_STATUS, 32'h3);
    rdc("pc", ADDR_COUNTER, 32'h0);
    m.send(32'h2A7, 1'b0);
    trig <= 1'b1;
    wplay();
    chk("sel", 32'h2A7, {22'h0, sel});
    rdc("status", ADDR_STATUS, 32'h1);
    rdc("irq_st", ADDR_IRQ_ST, 32'h6);
    wr(ADDR_PROG_LEN, 32'h4);
    // rerun stalls at the play step until a word arrives
    wr(ADDR_CTRL, 32'h5);
    rdc("status", ADDR_STATUS, 32'h2);
    rdc("pc", ADDR_COUNTER, 32'h1);
    for (int k = 0; k < 2; k++) begin
      d = 32'h1C3 + k;
      fork
        m.send(d, 1'b0);
        wplay();
      join
      chk("sel", d, {22'h0, sel});
    end
    wr(ADDR_CTRL, 32'h2);
    rdc("status", ADDR_STATUS, 32'h1);
    trig <= 1'b0;
    wr(ADDR_CTRL, 32'h9);
    repeat (2) @(posedge mclk_i);
    chk("sync_o", 32'h1, {31'h0, srdy});
    rdc("status", ADDR_STATUS, 32'h101);
    sall <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdc("status", ADDR_STATUS, 32'h3);
    wr(ADDR_CTRL, 32'h2);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTAB, {ct[k], 16'h2});
      rdc("ctab", ADDR_STATUS, {26'h0, ce[k], 4'h1});
    end
    wr(ADDR_CTAB, 32'h1);
    rdc("ctab", ADDR_STATUS, 32'h1);
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    tmo();
  end
endmodule : pcw_top_tb
